// ===== design/fwsr_host.sv
// flash status polling controller, host side top
//
// The implementer's own choices: the register offsets and strobed register access.
`include "fwsr_defines.svh"

module fwsr_host (
	input  wire logic                sys_clk_i,
	input  wire logic                reset_i,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [31:0]         reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic [31:0]              reg_rdata_o,
	output logic [`FWSR_AW-1:0]      flash_addr_o,
	input  wire logic [`FWSR_DW-1:0] flash_dq_i,
	output logic [`FWSR_DW-1:0]      flash_dq_o,
	output logic                     flash_dq_oe_n_o,
	output logic                     flash_ce_n_o,
	output logic                     flash_oe_n_o,
	output logic                     flash_we_n_o,
	input  wire logic                ready_busy_n_i
);

	fwsr_pkg::fwsr_state_t state;
	fwsr_pkg::fwsr_state_t next_state;
	fwsr_pkg::fwsr_req_t   req;
	fwsr_pkg::fwsr_cmp_t   cmp;
	logic [`FWSR_AW-1:0]   poll_addr;
	logic [`FWSR_DW-1:0]   wr_data;
	logic [`FWSR_DW-1:0]   rd_last;
	logic [`FWSR_DW-1:0]   bus_rdata;
	logic [`FWSR_DW-1:0]   last_wr_data;
	logic                  bus_busy;
	logic                  bus_done;
	logic                  req_v;
	logic                  issued;
	logic                  bus_state;
	logic                  is_idle;
	logic                  ctl_wr;
	logic                  cmd_start;
	logic                  cmd_abort;
	logic                  cmd_addsec;
	logic                  cmd_rawwr;
	logic                  cmd_rawrd;
	logic                  abort_req;
	logic                  done;
	logic                  fail;
	logic                  ew_bit;
	logic                  ew_refused;
	logic                  ew_unsure;
	logic                  aborted;
	logic                  poll_sample;
	logic [2:0]            rd_count;

	////////////////////////////////////////////////////////////////////////////
	// register port decode
	always_comb begin
		ctl_wr = 1'b0;
		if (reg_wr_i && reg_addr_i == `FWSR_REG_CTRL) begin
			ctl_wr = 1'b1;
		end
	end

	assign is_idle    = (state == fwsr_pkg::S_IDLE);
	assign cmd_start  = ctl_wr && reg_wdata_i[`FWSR_CTL_START];
	assign cmd_abort  = ctl_wr && reg_wdata_i[`FWSR_CTL_ABORT];
	assign cmd_addsec = ctl_wr && reg_wdata_i[`FWSR_CTL_ADDSEC];
	assign cmd_rawwr  = ctl_wr && reg_wdata_i[`FWSR_CTL_RAWWR];
	assign cmd_rawrd  = ctl_wr && reg_wdata_i[`FWSR_CTL_RAWRD];

	// address and data registers, frozen while a sequence runs
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			poll_addr <= '0;
			wr_data   <= '0;
		end else if (reg_wr_i && is_idle) begin
			if (reg_addr_i == `FWSR_REG_ADDR) begin
				poll_addr <= reg_wdata_i[`FWSR_AW-1:0];
			end else if (reg_addr_i == `FWSR_REG_DATA) begin
				wr_data <= reg_wdata_i[`FWSR_DW-1:0];
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= '0;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= '0;
		end else if (reg_addr_i == `FWSR_REG_ADDR) begin
			reg_rdata_o <= 32'(poll_addr);
		end else if (reg_addr_i == `FWSR_REG_DATA) begin
			reg_rdata_o <= 32'(wr_data);
		end else if (reg_addr_i == `FWSR_REG_STATUS) begin
			reg_rdata_o <= {22'h0, aborted, ~ready_busy_n_i, ew_unsure, ew_refused,
				ew_bit, cmp.sector_tog, cmp.toggling, fail, done, ~is_idle};
		end else if (reg_addr_i == `FWSR_REG_RDATA) begin
			reg_rdata_o <= 32'(rd_last);
		end else begin
			reg_rdata_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequence state machine
	always_comb begin
		next_state = state;
		case (state)
			fwsr_pkg::S_IDLE: begin
				if (cmd_start) begin
					next_state = fwsr_pkg::S_POLL1;
				end else if (cmd_addsec) begin
					next_state = fwsr_pkg::S_EW_PRE;
				end else if (cmd_rawwr) begin
					next_state = fwsr_pkg::S_RAW_WR;
				end else if (cmd_rawrd) begin
					next_state = fwsr_pkg::S_RAW_RD;
				end
			end
			fwsr_pkg::S_POLL1: begin
				if (bus_done) begin
					next_state = abort_req ? fwsr_pkg::S_IDLE : fwsr_pkg::S_POLL2;
				end
			end
			fwsr_pkg::S_POLL2: begin
				if (bus_done) begin
					next_state = abort_req ? fwsr_pkg::S_IDLE : fwsr_pkg::S_CHECK;
				end
			end
			// steady toggle bit ends the poll
			fwsr_pkg::S_CHECK: begin
				if (!cmp.toggling) begin
					next_state = fwsr_pkg::S_IDLE;
				end else if (cmp.fail) begin
					next_state = fwsr_pkg::S_RECHECK;
				end else if (abort_req) begin
					next_state = fwsr_pkg::S_IDLE;
				end else begin
					next_state = fwsr_pkg::S_POLL1;
				end
			end
			// one more read after timeout bit seen
			fwsr_pkg::S_RECHECK: begin
				if (bus_done) next_state = fwsr_pkg::S_VERDICT;
			end
			fwsr_pkg::S_VERDICT: begin
				next_state = cmp.toggling ? fwsr_pkg::S_RESET : fwsr_pkg::S_IDLE;
			end
			// window bit checked before the sector command
			fwsr_pkg::S_EW_PRE: begin
				if (bus_done) begin
					next_state = bus_rdata[`FWSR_DQ_EWIN] ? fwsr_pkg::S_IDLE
						: fwsr_pkg::S_SE_WR;
				end
			end
			fwsr_pkg::S_SE_WR: begin
				if (bus_done) next_state = fwsr_pkg::S_EW_POST;
			end
			default: begin
				if (bus_done) next_state = fwsr_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= fwsr_pkg::S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus requests: one cycle per bus state
	assign bus_state = !(is_idle || state == fwsr_pkg::S_CHECK
		|| state == fwsr_pkg::S_VERDICT);
	assign req_v = bus_state && !issued && !bus_busy;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || bus_done) begin
			issued <= 1'b0;
		end else if (req_v) begin
			issued <= 1'b1;
		end
	end

	// status reads use the held poll address
	always_comb begin
		req.addr = poll_addr;
		req.wr   = 1'b0;
		req.data = wr_data;
		if (state == fwsr_pkg::S_RAW_WR) begin
			req.wr = 1'b1;
		end else if (state == fwsr_pkg::S_RESET) begin
			req.wr   = 1'b1;
			req.data = `FWSR_CMD_RESET;
		end else if (state == fwsr_pkg::S_SE_WR) begin
			req.wr   = 1'b1;
			req.data = `FWSR_CMD_SECTOR;
		end
	end

	fwsr_bus_cycle u_bus (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.req_valid_i (req_v),
		.req_i       (req),
		.busy_o      (bus_busy),
		.done_o      (bus_done),
		.rdata_o     (bus_rdata),
		.addr_o      (flash_addr_o),
		.dq_i        (flash_dq_i),
		.dq_o        (flash_dq_o),
		.dq_oe_n_o   (flash_dq_oe_n_o),
		.ce_n_o      (flash_ce_n_o),
		.oe_n_o      (flash_oe_n_o),
		.we_n_o      (flash_we_n_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// every start clears the read history
	assign poll_sample = bus_done && (state == fwsr_pkg::S_POLL1
		|| state == fwsr_pkg::S_POLL2 || state == fwsr_pkg::S_RECHECK);

	fwsr_toggle_cmp u_cmp (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.clear_i   (is_idle && cmd_start),
		.sample_i  (poll_sample),
		.data_i    (bus_rdata),
		.cmp_o     (cmp)
	);

	// reads seen since the last start
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || (is_idle && cmd_start)) begin
			rd_count <= 3'h0;
		end else if (poll_sample && rd_count != 3'h7) begin
			rd_count <= rd_count + 3'h1;
		end
	end

	// last read word and last written word
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rd_last      <= '0;
			last_wr_data <= '0;
		end else if (bus_done) begin
			if (req.wr) last_wr_data <= req.data;
			else rd_last <= bus_rdata;
		end
	end

	// abort request, honoured at the end of the next poll read
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || is_idle) begin
			abort_req <= 1'b0;
		end else if (cmd_abort) begin
			abort_req <= 1'b1;
		end
	end

	// completion and failure flags
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			done    <= 1'b0;
			fail    <= 1'b0;
			aborted <= 1'b0;
		end else if (is_idle && cmd_start) begin
			done    <= 1'b0;
			fail    <= 1'b0;
			aborted <= 1'b0;
		end else begin
			if ((state == fwsr_pkg::S_CHECK || state == fwsr_pkg::S_VERDICT)
				&& !cmp.toggling) begin
				done <= 1'b1;
			end
			if (state == fwsr_pkg::S_RESET && bus_done) fail <= 1'b1;
			if (!is_idle && next_state == fwsr_pkg::S_IDLE && abort_req) aborted <= 1'b1;
		end
	end

	// window bit before and after the sector command
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || (is_idle && cmd_addsec)) begin
			ew_bit     <= 1'b0;
			ew_refused <= 1'b0;
			ew_unsure  <= 1'b0;
		end else if (bus_done && state == fwsr_pkg::S_EW_PRE) begin
			ew_bit     <= bus_rdata[`FWSR_DQ_EWIN];
			ew_refused <= bus_rdata[`FWSR_DQ_EWIN];
		end else if (bus_done && state == fwsr_pkg::S_EW_POST) begin
			ew_bit    <= bus_rdata[`FWSR_DQ_EWIN];
			ew_unsure <= bus_rdata[`FWSR_DQ_EWIN];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_first_read;
		state == fwsr_pkg::S_POLL1 && bus_done;
	endsequence

	sequence s_still_toggling;
		state == fwsr_pkg::S_RECHECK && bus_done ##1
			state == fwsr_pkg::S_VERDICT && cmp.toggling;
	endsequence

	a_poll_addr_hold: assert property (!is_idle |=> $stable(poll_addr))
		else $error("poll address changed during a sequence");
	a_two_reads_done: assert property ($rose(done) |-> cmp.pair_ok && rd_count >= 3'h2)
		else $error("completion declared before two reads");
	a_second_read: assert property (s_first_read |=>
		state == fwsr_pkg::S_POLL2 || state == fwsr_pkg::S_IDLE)
		else $error("first status read not followed by second");
	a_fail_recheck: assert property (s_still_toggling |=> state == fwsr_pkg::S_RESET)
		else $error("toggle after recheck did not lead to reset");
	a_restart_pair: assert property (is_idle && cmd_start |=>
		state == fwsr_pkg::S_POLL1 && rd_count == 3'h0)
		else $error("poll did not restart from first read");
	a_reset_written: assert property ($rose(fail) |-> last_wr_data == `FWSR_CMD_RESET)
		else $error("failure flagged without reset command");
	a_window_refuse: assert property (state == fwsr_pkg::S_EW_PRE && bus_done
		&& bus_rdata[`FWSR_DQ_EWIN] |=> is_idle && ew_refused)
		else $error("sector command issued with window closed");
	a_window_after: assert property (state == fwsr_pkg::S_SE_WR && bus_done |=>
		state == fwsr_pkg::S_EW_POST ##[1:30] (bus_done && state == fwsr_pkg::S_EW_POST))
		else $error("window bit not rechecked after sector command");

endmodule

// ===== design/fwsr_defines.svh
// constants for the flash status polling controller
// Contract
// - Host reads status at the programmed address or an erasing sector.
// - Host reads status twice back to back; unchanged toggle means complete.
// - Toggling with timeout bit high: recheck once, still toggling means failed.
// - Host resuming after other work restarts from the first double read.
// - After any timeout failure the host writes the reset command.
// - Host may skip the window bit only with sector commands under 50 us apart.
// - Host confirms acceptance, then checks window bit before and after each sector; code only reads the window bit, in S_EW_PRE and S_EW_POST.
`ifndef FWSR_DEFINES_SVH
`define FWSR_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// widths
`define FWSR_AW           20
`define FWSR_DW           16

////////////////////////////////////////////////////////////////////////////////
// software register offsets
`define FWSR_REG_CTRL     8'h00
`define FWSR_REG_ADDR     8'h04
`define FWSR_REG_DATA     8'h08
`define FWSR_REG_STATUS   8'h0C
`define FWSR_REG_RDATA    8'h10

// control register command bits
`define FWSR_CTL_START    0
`define FWSR_CTL_ABORT    1
`define FWSR_CTL_ADDSEC   2
`define FWSR_CTL_RAWWR    3
`define FWSR_CTL_RAWRD    4

////////////////////////////////////////////////////////////////////////////////
// status bit positions on the flash data bus
`define FWSR_DQ_POLL      7
`define FWSR_DQ_TOG1      6
`define FWSR_DQ_FAIL      5
`define FWSR_DQ_EWIN      3
`define FWSR_DQ_TOG2      2

// flash command words
`define FWSR_CMD_RESET    16'h00F0
`define FWSR_CMD_SECTOR   16'h0030

////////////////////////////////////////////////////////////////////////////////
// timing
`define FWSR_CLK_NS       8
`define FWSR_STROBE_NS    80
`define FWSR_STROBE_CYC   ((`FWSR_STROBE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)

`endif

// ===== design/fwsr_pkg.sv
// types shared by the flash status polling controller
`include "fwsr_defines.svh"

package fwsr_pkg;

	// one flash bus cycle request
	typedef struct packed {
		logic                 wr;
		logic [`FWSR_AW-1:0] addr;
		logic [`FWSR_DW-1:0] data;
	} fwsr_req_t;

	// result of comparing successive status reads
	typedef struct packed {
		logic pair_ok;
		logic toggling;
		logic sector_tog;
		logic fail;
	} fwsr_cmp_t;

	typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fwsr_bus_state_t;

	typedef enum logic [3:0] {
		S_IDLE, S_RAW_WR, S_RAW_RD, S_POLL1, S_POLL2, S_CHECK, S_RECHECK,
		S_VERDICT, S_RESET, S_EW_PRE, S_SE_WR, S_EW_POST
	} fwsr_state_t;

endpackage

// ===== design/fwsr_bus_cycle.sv
// single asynchronous flash bus cycle engine
`include "fwsr_defines.svh"

module fwsr_bus_cycle (
	input  wire logic                sys_clk_i,
	input  wire logic                reset_i,
	input  wire logic                req_valid_i,
	input  fwsr_pkg::fwsr_req_t      req_i,
	output logic                     busy_o,
	output logic                     done_o,
	output logic [`FWSR_DW-1:0]      rdata_o,
	output logic [`FWSR_AW-1:0]      addr_o,
	input  wire logic [`FWSR_DW-1:0] dq_i,
	output logic [`FWSR_DW-1:0]      dq_o,
	output logic                     dq_oe_n_o,
	output logic                     ce_n_o,
	output logic                     oe_n_o,
	output logic                     we_n_o
);

	fwsr_pkg::fwsr_bus_state_t state;
	logic [3:0]                cnt;
	logic                      wr;
	logic                      last;

	assign busy_o = (state != fwsr_pkg::B_IDLE);
	assign last   = (state == fwsr_pkg::B_STROBE) && (cnt == 4'h0);

	////////////////////////////////////////////////////////////////////////////
	// cycle sequencing: setup, strobe, hold
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= fwsr_pkg::B_IDLE;
		end else begin
			case (state)
				fwsr_pkg::B_IDLE:   if (req_valid_i) state <= fwsr_pkg::B_SETUP;
				fwsr_pkg::B_SETUP:  state <= fwsr_pkg::B_STROBE;
				fwsr_pkg::B_STROBE: if (last) state <= fwsr_pkg::B_HOLD;
				default:            state <= fwsr_pkg::B_IDLE;
			endcase
		end
	end

	// strobe width counter
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cnt <= 4'h0;
		end else if (state == fwsr_pkg::B_SETUP) begin
			cnt <= 4'(`FWSR_STROBE_CYC - 1);
		end else if (state == fwsr_pkg::B_STROBE) begin
			cnt <= cnt - 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ce_n_o    <= 1'b1;
			oe_n_o    <= 1'b1;
			we_n_o    <= 1'b1;
			dq_oe_n_o <= 1'b1;
			addr_o    <= '0;
			dq_o      <= '0;
			wr        <= 1'b0;
		end else if (state == fwsr_pkg::B_IDLE && req_valid_i) begin
			addr_o    <= req_i.addr;
			dq_o      <= req_i.data;
			wr        <= req_i.wr;
			ce_n_o    <= 1'b0;
			dq_oe_n_o <= ~req_i.wr; // low while driving
		end else if (state == fwsr_pkg::B_SETUP) begin
			oe_n_o <= wr;
			we_n_o <= ~wr;
		end else if (last) begin
			oe_n_o <= 1'b1;
			we_n_o <= 1'b1; // rising edge latches the write
		end else if (state == fwsr_pkg::B_HOLD) begin
			ce_n_o    <= 1'b1;
			dq_oe_n_o <= 1'b1;
		end
	end

	// capture read data and flag completion
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rdata_o <= '0;
			done_o  <= 1'b0;
		end else begin
			done_o <= last;
			if (last && !wr) rdata_o <= dq_i;
		end
	end

endmodule

// ===== design/fwsr_toggle_cmp.sv
// compares successive status reads for toggling bits
`include "fwsr_defines.svh"

module fwsr_toggle_cmp (
	input  wire logic                sys_clk_i,
	input  wire logic                reset_i,
	input  wire logic                clear_i,
	input  wire logic                sample_i,
	input  wire logic [`FWSR_DW-1:0] data_i,
	output fwsr_pkg::fwsr_cmp_t      cmp_o
);

	logic [`FWSR_DW-1:0] prev;
	logic [1:0]          seen;

	// count samples since the last clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || clear_i) begin
			seen <= 2'h0;
		end else if (sample_i && seen != 2'h2) begin
			seen <= seen + 2'h1;
		end
	end

	// compare toggle bits of two reads
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || clear_i) begin
			prev  <= '0;
			cmp_o <= '0;
		end else if (sample_i) begin
			prev             <= data_i;
			cmp_o.pair_ok    <= (seen != 2'h0);
			cmp_o.toggling   <= data_i[`FWSR_DQ_TOG1] ^ prev[`FWSR_DQ_TOG1];
			cmp_o.sector_tog <= data_i[`FWSR_DQ_TOG2] ^ prev[`FWSR_DQ_TOG2];
			cmp_o.fail       <= data_i[`FWSR_DQ_FAIL];
		end
	end

endmodule

// ===== tb/fwsr_flash_model.sv
// behavioural flash device answering status polls
module fwsr_flash_model (
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [19:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic [15:0]      dq_o,
	output logic             ready_busy_n_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        busy, erasing, fail, susp, ewin, unsure_arm, tog1, tog2, in_sec;
	logic [15:0] pdat, array_word, word, last_q, wr_data;
	logic [19:0] sec_addr, wr_addr;
	int          reads_left, n_reset, n_sector;

	// power-up: array reads, nothing pending
	initial begin
		{busy, erasing, fail, susp, ewin, unsure_arm, tog1, tog2} = 8'h00;
		{pdat, last_q, wr_data, wr_addr, sec_addr} = '0;
		array_word = 16'hC300;
		{reads_left, n_reset, n_sector} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign in_sec = (addr_i[19:12] == sec_addr[19:12]);
	// open drain, pulled up when released
	assign ready_busy_n_o = ~(busy | fail);

	// status word while an operation runs, array data otherwise
	always_comb begin
		word = array_word;
		// reads outside suspended sectors see the array
		if (busy || fail || (susp && in_sec)) begin
			word = 16'h0000;
			// complement during program, 0 while erasing
			word[7] = susp ? 1'b1 : (erasing ? 1'b0 : ~pdat[7]);
			word[6] = (busy | fail) & tog1;
			word[5] = fail;
			word[3] = ewin;
			word[2] = (erasing | susp) & in_sec & tog2;
		end
	end

	// released bus shows the inverse of the last word, never a stale value
	assign dq_o = (!ce_n_i && !oe_n_i) ? word : ~last_q;

	// a read ends on whichever strobe rises first
	always @(posedge oe_n_i or posedge ce_n_i) begin
		if (oe_n_i != ce_n_i) begin
			last_q = word;
			if (busy || fail)
				tog1 = ~tog1;
			if ((erasing || susp) && in_sec)
				tog2 = ~tog2;
			if (busy && reads_left > 0)
				reads_left--;
			if (busy && reads_left == 0) begin
				busy = 1'b0;
				erasing = 1'b0;
			end
		end
	end

	// command words latch on the rising write strobe
	// status valid from write strobe rise
	always @(posedge we_n_i) begin
		if (!ce_n_i) begin
			wr_addr = addr_i;
			wr_data = dq_i;
			// reset command returns to array reads
			if (dq_i == 16'h00F0) begin
				n_reset++;
				fail = 1'b0;
				busy = 1'b0;
			end
			// sector command taken only while the window is open
			if (dq_i == 16'h0030 && !ewin) begin
				n_sector++;
				ewin = unsure_arm;
			end
			// suspend honoured only during sector erase
			if (dq_i == 16'h00B0 && erasing) begin
				susp = 1'b1;
				busy = 1'b0;
			end
		end
	end
endmodule

// ===== tb/fwsr_host_tb_top.sv
// testbench for the flash status polling controller
`include "fwsr_defines.svh"

module fwsr_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        sys_clk_i, reset_i, reg_wr_i, reg_rd_i, rb_n, dq_oe_n, ce_n, oe_n, we_n;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, s;
	logic [19:0] fa;
	logic [15:0] hq, mq, dq;
	int          miscompares, total_checks, nr, ns;

	fwsr_host dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .flash_addr_o(fa), .flash_dq_i(dq), .flash_dq_o(hq),
		.flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
		.flash_we_n_o(we_n), .ready_busy_n_i(rb_n));

	fwsr_flash_model fm (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(hq),
		.dq_o(mq), .ready_busy_n_o(rb_n));

	// shared data wire: whoever is enabled drives it
	assign dq = dq_oe_n ? mq : hq;

	// 125 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// poll status until the controller is idle, bounded
	task automatic wait_idle;
		for (int i = 0; i < 400; i++) begin
			reg_rd(`FWSR_REG_STATUS, s);
			if (s[0] === 1'b0)
				return;
		end
		miscompares++;
		$display("CHECK FAILED at %0t: controller never idle", $time);
		print_verdict;
	endtask

	task automatic run_cmd(input logic [19:0] a, input logic [31:0] c);
		reg_wr(`FWSR_REG_ADDR, {12'h000, a});
		reg_wr(`FWSR_REG_CTRL, c);
		wait_idle;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		reg_rd(`FWSR_REG_STATUS, s);
		check(s, 32'h0000_0000, "status after reset");
		reg_rd(8'h20, s);
		check(s, 32'h0000_0000, "unmapped read");
		$display("test reset done");
	endtask

	task automatic t_poll_ok;
		fm.pdat = 16'h0080;
		fm.reads_left = 5;
		fm.busy = 1'b1;
		reg_wr(`FWSR_REG_ADDR, 32'h0000_1234);
		reg_wr(`FWSR_REG_CTRL, 32'h0000_0001);
		reg_rd(`FWSR_REG_STATUS, s);
		check(s & 32'h101, 32'h101, "busy while device busy");
		wait_idle;
		check(s & 32'h207, 32'h002, "poll completes");
		reg_rd(`FWSR_REG_RDATA, s);
		check(s, 32'h0000_C300, "array data after completion");
		$display("test poll_ok done");
	endtask

	task automatic t_poll_fail;
		nr = fm.n_reset;
		fm.fail = 1'b1;
		run_cmd(20'h02000, 32'h0000_0001);
		check(s & 32'h00F, 32'h00C, "timeout failure reported");
		check(fm.n_reset, nr + 1, "reset command written");
		check({12'h000, fm.wr_addr}, 32'h0000_2000, "reset at poll address");
		$display("test poll_fail done");
	endtask

	task automatic t_sector;
		ns = fm.n_sector;
		fm.sec_addr = 20'h40000;
		fm.reads_left = 100000;
		fm.erasing = 1'b1;
		fm.busy = 1'b1;
		run_cmd(20'h41000, 32'h0000_0004);
		check(s & 32'h0C0, 32'h000, "sector accepted");
		check(fm.n_sector, ns + 1, "sector command written");
		fm.unsure_arm = 1'b1;
		run_cmd(20'h41000, 32'h0000_0004);
		check(s & 32'h0C0, 32'h080, "window closed after command");
		run_cmd(20'h41000, 32'h0000_0004);
		check(s & 32'h0C0, 32'h040, "refused with window closed");
		check(fm.n_sector, ns + 2, "no command when refused");
		$display("test sector done");
	endtask

	task automatic t_abort;
		reg_wr(`FWSR_REG_ADDR, 32'h0004_0000);
		reg_wr(`FWSR_REG_CTRL, 32'h0000_0001);
		repeat (40) @(posedge sys_clk_i);
		reg_wr(`FWSR_REG_CTRL, 32'h0000_0002);
		wait_idle;
		check(s & 32'h200, 32'h200, "abort flagged");
		{fm.busy, fm.erasing} = 2'b00;
		$display("test abort done");
	endtask

	task automatic t_suspend;
		fm.susp = 1'b1;
		run_cmd(20'h40010, 32'h0000_0001);
		check(s & 32'h11F, 32'h012, "suspended sector status");
		run_cmd(20'h00100, 32'h0000_0010);
		reg_rd(`FWSR_REG_RDATA, s);
		check(s, 32'h0000_C300, "array outside suspended sector");
		reg_wr(`FWSR_REG_DATA, 32'h0000_A5C3);
		run_cmd(20'h00555, 32'h0000_0008);
		check({16'h0000, fm.wr_data}, 32'h0000_A5C3, "raw write data");
		check({12'h000, fm.wr_addr}, 32'h0000_0555, "raw write address");
		$display("test suspend done");
	endtask

	// main sequence
	initial begin
		{reset_i, reg_wr_i, reg_rd_i} = 3'b100;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0000_0000;
		{miscompares, total_checks} = '0;
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_poll_ok;
		t_poll_fail;
		t_sector;
		t_abort;
		t_suspend;
		print_verdict;
	end
endmodule
